//--- bps_top.sv
// backup power supervisor: switchover, host gating, timestamps, flags
// assumes comparator outputs asynchronous, time bus from calendar logic
// Functional notes
// - enter backup: below battery-hys and trip
// - leave backup: above battery+hys or trip+hys
// - host interface disabled during backup
// - other functions stay active in backup, except the battery monitor and, unless enabled, temp compensation
// - capture time at first powerdown after a clear and at each powerup
// - keep earliest powerdown, latest powerup stamp
// - stamp held until host clear bit
// - temp compensation in backup only if enabled
// - flag total power loss at power up
// - brownout flag from six selectable levels
// - brownout leaves host interface enabled
// - battery flags at 85 and 75 percent
// - battery monitor idle during backup
// - temp sense enable starts battery measurement
`timescale 1ns/1ps
`default_nettype none
module bps_top import bps_pkg::*; (
	input  wire logic                  clk_in,
	input  wire logic                  nrst_in,
	input  wire logic                  vdd_lt_bat_m_hys_in,
	input  wire logic                  vdd_gt_bat_p_hys_in,
	input  wire logic                  vdd_lt_trip_in,
	input  wire logic                  vdd_gt_trip_p_hys_in,
	input  wire logic [5:0]            vdd_below_level_in,
	input  wire logic                  bat_below85_in,
	input  wire logic                  bat_below75_in,
	input  wire logic                  total_loss_in,
	input  wire logic [BPS_TS_W-1:0]   time_in,
	input  wire logic [BPS_ADDR_W-1:0] addr_in,
	input  wire logic [BPS_DATA_W-1:0] wdata_in,
	input  wire logic                  wr_in,
	input  wire logic                  rd_in,
	output var  logic [BPS_DATA_W-1:0] rdata_out,
	output var  logic                  backup_out,
	output var  logic                  host_enable_out,
	output var  logic                  temp_comp_run_out
);
	bps_cmp_type                       cmp_raw;
	bps_cmp_type                       cmp;
	bps_bus_type                       bus;
	logic [5:0]                        bo_lvl;
	logic [2:0]                        misc_s;
	bps_mode_type                      mode_r;
	bps_mode_type                      mode_nxt;
	logic                              tse_r;
	logic                              backup_temp_sense_enable_r;
	logic [2:0]                        bosel_r;
	logic                              tpl_flag_r;
	logic                              bo_flag_r;
	logic                              tsdn_valid_r;
	logic [BPS_TS_W-1:0]               tsdn_r;
	logic [BPS_TS_W-1:0]               tsup_r;
	logic                              meas_start_r;
	logic                              bat_busy;
	logic                              bat_low1;
	logic                              bat_low2;
	logic                              wr_ok;
	logic                              rd_ok;
	logic                              clr_ts;
	logic [BPS_DATA_W-1:0]             rd_nxt;
	logic [BPS_DATA_W-1:0]             status_v;

	assign cmp_raw = '{vdd_lt_bat_m_hys_in, vdd_gt_bat_p_hys_in, vdd_lt_trip_in, vdd_gt_trip_p_hys_in};
	assign bus     = '{addr_in, wdata_in, wr_in, rd_in};

	bps_sync #(.W(4)) u_sync_cmp (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.d_in    (cmp_raw),
		.q_out   (cmp)
	);
	bps_sync #(.W(6)) u_sync_bo (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.d_in    (vdd_below_level_in),
		.q_out   (bo_lvl)
	);
	bps_sync #(.W(3)) u_sync_misc (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.d_in    ({bat_below85_in, bat_below75_in, total_loss_in}),
		.q_out   (misc_s)
	);

	// switchover decision, evaluated every cycle
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			BPS_NORMAL: begin
				if (cmp.vdd_lt_bat_m_hys && cmp.vdd_lt_trip) begin
					mode_nxt = BPS_BACKUP;
				end
			end
			BPS_BACKUP: begin
				if (cmp.vdd_gt_bat_p_hys || cmp.vdd_gt_trip_p_hys) begin
					mode_nxt = BPS_NORMAL;
				end
			end
			default: mode_nxt = BPS_NORMAL;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			mode_r <= BPS_NORMAL;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// host access only in normal mode; brownout plays no part
	assign wr_ok  = bus.wr && (mode_r == BPS_NORMAL);
	assign rd_ok  = bus.rd && (mode_r == BPS_NORMAL);
	assign clr_ts = wr_ok && (bus.addr == BPS_OFF_CTRL) && bus.wdata[BPS_CT_TIMESTAMP_CLEAR];

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			tse_r        <= 1'b0;
			backup_temp_sense_enable_r       <= BPS_BACKUP_TEMP_SENSE_ENABLE_RST;
			bosel_r      <= BPS_BOSEL_RST;
			meas_start_r <= 1'b0;
		end else begin
			meas_start_r <= 1'b0;
			if (wr_ok && bus.addr == BPS_OFF_CTRL) begin
				tse_r        <= bus.wdata[BPS_CT_TSE];
				backup_temp_sense_enable_r       <= bus.wdata[BPS_CT_BACKUP_TEMP_SENSE_ENABLE];
				bosel_r      <= bus.wdata[BPS_CT_BOSEL +: 3];
				meas_start_r <= bus.wdata[BPS_CT_TSE];
			end
		end
	end

	// timestamps: set on the switchover wins over a clear
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			tsdn_r       <= '0;
			tsdn_valid_r <= 1'b0;
		end else if (mode_r == BPS_NORMAL && mode_nxt == BPS_BACKUP && (!tsdn_valid_r || clr_ts)) begin
			tsdn_r       <= time_in;
			tsdn_valid_r <= 1'b1;
		end else if (clr_ts) begin
			tsdn_r       <= '0;
			tsdn_valid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			tsup_r <= '0;
		end else if (mode_r == BPS_BACKUP && mode_nxt == BPS_NORMAL) begin
			tsup_r <= time_in;
		end else if (clr_ts) begin
			tsup_r <= '0;
		end
	end

	// status flags: hardware set wins over a host clear by writing 0
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			tpl_flag_r <= 1'b0;
			bo_flag_r  <= 1'b0;
		end else begin
			if (misc_s[0]) begin
				tpl_flag_r <= 1'b1;
			end else if (wr_ok && bus.addr == BPS_OFF_STATUS && !bus.wdata[BPS_ST_TPL]) begin
				tpl_flag_r <= 1'b0;
			end
			if (bosel_r < 3'(BPS_BO_LVL_N) && bo_lvl[bosel_r]) begin
				bo_flag_r <= 1'b1;
			end else if (wr_ok && bus.addr == BPS_OFF_STATUS && !bus.wdata[BPS_ST_BO]) begin
				bo_flag_r <= 1'b0;
			end
		end
	end

	bps_batmon u_batmon (
		.clk_in         (clk_in),
		.nrst_in        (nrst_in),
		.start_in       (meas_start_r),
		.backup_in      (mode_r == BPS_BACKUP),
		.below85_in     (misc_s[2]),
		.below75_in     (misc_s[1]),
		.busy_out       (bat_busy),
		.low_first_out  (bat_low1),
		.low_second_out (bat_low2)
	);

	always_comb begin
		status_v = '0;
		status_v[BPS_ST_TPL]    = tpl_flag_r;
		status_v[BPS_ST_BAT2]   = bat_low2;
		status_v[BPS_ST_BAT1]   = bat_low1;
		status_v[BPS_ST_BO]     = bo_flag_r;
		status_v[BPS_ST_BACKUP] = (mode_r == BPS_BACKUP);
		status_v[BPS_ST_TSDN_V] = tsdn_valid_r;
		status_v[BPS_ST_BUSY]   = bat_busy;
	end

	always_comb begin
		rd_nxt = '0;
		case (bus.addr)
			BPS_OFF_STATUS:  rd_nxt = status_v;
			BPS_OFF_CTRL:    rd_nxt = {25'h0000000, bosel_r, 2'h0, backup_temp_sense_enable_r, tse_r};
			BPS_OFF_TSDN_LO: rd_nxt = tsdn_r[31:0];
			BPS_OFF_TSDN_HI: rd_nxt = {16'h0000, tsdn_r[47:32]};
			BPS_OFF_TSUP_LO: rd_nxt = tsup_r[31:0];
			BPS_OFF_TSUP_HI: rd_nxt = {16'h0000, tsup_r[47:32]};
			default:         rd_nxt = '0;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= rd_ok ? rd_nxt : '0;
		end
	end

	// outputs: other functions keep running, temp only with enable
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			backup_out        <= 1'b0;
			host_enable_out   <= 1'b1;
			temp_comp_run_out <= 1'b1;
		end else begin
			backup_out        <= (mode_nxt == BPS_BACKUP);
			host_enable_out   <= (mode_nxt == BPS_NORMAL);
			temp_comp_run_out <= (mode_nxt == BPS_NORMAL) || backup_temp_sense_enable_r;
		end
	end
endmodule
`default_nettype wire

//--- bps_pkg.sv
// package for the backup power supervisor: constants, types
// assumes one 125 MHz clock domain, synchronous active-low reset
package bps_pkg;
	localparam int           BPS_TS_W        = 48;
	localparam int           BPS_ADDR_W      = 4;
	localparam int           BPS_DATA_W      = 32;
	localparam int           BPS_BO_LVL_N    = 6;
	// register offsets (byte addresses)
	localparam logic [3:0]   BPS_OFF_STATUS  = 4'h0;
	localparam logic [3:0]   BPS_OFF_CTRL    = 4'h4;
	localparam logic [3:0]   BPS_OFF_TSDN_LO = 4'h8;
	localparam logic [3:0]   BPS_OFF_TSDN_HI = 4'hC;
	localparam logic [3:0]   BPS_OFF_TSUP_LO = 4'h1;
	localparam logic [3:0]   BPS_OFF_TSUP_HI = 4'h2;
	// status fields
	localparam int           BPS_ST_TPL      = 0;
	localparam int           BPS_ST_BAT2     = 1;
	localparam int           BPS_ST_BAT1     = 2;
	localparam int           BPS_ST_BO       = 3;
	localparam int           BPS_ST_BACKUP   = 4;
	localparam int           BPS_ST_TSDN_V   = 5;
	localparam int           BPS_ST_BUSY     = 6;
	// control fields
	localparam int           BPS_CT_TSE      = 0;
	localparam int           BPS_CT_BACKUP_TEMP_SENSE_ENABLE     = 1;
	localparam int           BPS_CT_TIMESTAMP_CLEAR    = 2;
	localparam int           BPS_CT_BOSEL    = 4;
	localparam logic [2:0]   BPS_BOSEL_RST   = 3'h0;
	localparam logic         BPS_BACKUP_TEMP_SENSE_ENABLE_RST    = 1'b0;
	// battery measurement time
	localparam int           BPS_MEAS_NS     = 1000;
	localparam int           BPS_CLK_NS      = 8;
	localparam int           BPS_MEAS_CYC    = (BPS_MEAS_NS + BPS_CLK_NS - 1) / BPS_CLK_NS;
	localparam logic [7:0]   BPS_MEAS_CNT    = 8'(BPS_MEAS_CYC);
	typedef struct packed {
		logic vdd_lt_bat_m_hys;
		logic vdd_gt_bat_p_hys;
		logic vdd_lt_trip;
		logic vdd_gt_trip_p_hys;
	} bps_cmp_type;
	typedef struct packed {
		logic [BPS_ADDR_W-1:0] addr;
		logic [BPS_DATA_W-1:0] wdata;
		logic                  wr;
		logic                  rd;
	} bps_bus_type;
	typedef enum logic [0:0] {BPS_NORMAL, BPS_BACKUP} bps_mode_type;
endpackage

//--- bps_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
// assumes inputs come from analog comparators outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module bps_sync import bps_pkg::*; #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	input  wire logic [W-1:0] d_in,
	output var  logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			meta_r <= '0;
			q_out  <= '0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- bps_batmon.sv
// battery level measurement: one run per start pulse
// assumes synchronised level comparator inputs
`timescale 1ns/1ps
`default_nettype none
module bps_batmon import bps_pkg::*; (
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic start_in,
	input  wire logic backup_in,
	input  wire logic below85_in,
	input  wire logic below75_in,
	output var  logic busy_out,
	output var  logic low_first_out,
	output var  logic low_second_out
);
	logic [7:0] cnt_r;
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			cnt_r          <= 8'h00;
			busy_out       <= 1'b0;
			low_first_out  <= 1'b0;
			low_second_out <= 1'b0;
		end else if (backup_in) begin
			// monitor stopped in backup, run in progress abandoned, flags kept
			cnt_r    <= 8'h00;
			busy_out <= 1'b0;
		end else if (start_in && !busy_out) begin
			cnt_r    <= BPS_MEAS_CNT;
			busy_out <= 1'b1;
		end else if (busy_out) begin
			if (cnt_r == 8'h01) begin
				busy_out       <= 1'b0;
				low_first_out  <= below85_in || below75_in;
				low_second_out <= below75_in;
			end
			cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule
`default_nettype wire

//--- bps_top_properties.sv
// checker on the supervisor top ports
// assumes bound into every bps_top instance
`timescale 1ns/1ps
`default_nettype none
module bps_chk import bps_pkg::*; (
	input wire logic                  clk_in,
	input wire logic                  nrst_in,
	input wire logic                  vdd_lt_bat_m_hys_in,
	input wire logic                  vdd_gt_bat_p_hys_in,
	input wire logic                  vdd_lt_trip_in,
	input wire logic                  vdd_gt_trip_p_hys_in,
	input wire logic                  rd_in,
	input wire logic [BPS_DATA_W-1:0] rdata_out,
	input wire logic                  backup_out,
	input wire logic                  host_enable_out,
	input wire logic                  temp_comp_run_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// pins pass two flops, mode and outputs one more edge
	sequence s_enter;
		$past(vdd_lt_bat_m_hys_in, 3) && $past(vdd_lt_trip_in, 3);
	endsequence
	sequence s_leave;
		$past(vdd_gt_bat_p_hys_in, 3) || $past(vdd_gt_trip_p_hys_in, 3);
	endsequence
	a_enter_backup: assert property ($rose(backup_out) |-> s_enter) else $error("bad entry");
	a_leave_backup: assert property ($fell(backup_out) |-> s_leave) else $error("bad return");
	a_stay_normal: assert property (!backup_out &&
		!($past(vdd_lt_bat_m_hys_in, 2) && $past(vdd_lt_trip_in, 2)) |=> !backup_out)
		else $error("left normal");
	a_stay_backup: assert property (backup_out &&
		!$past(vdd_gt_bat_p_hys_in, 2) && !$past(vdd_gt_trip_p_hys_in, 2) |=> backup_out)
		else $error("left backup");
	a_host_gate: assert property (host_enable_out == !backup_out) else $error("host gate");
	a_read_blocked: assert property (backup_out && rd_in |=> rdata_out == '0) else $error("read in backup");
	a_temp_normal: assert property (!backup_out |-> temp_comp_run_out) else $error("temp off");
	a_temp_hold: assert property (backup_out && $past(backup_out) |-> $stable(temp_comp_run_out))
		else $error("temp moved");
endmodule
bind bps_top bps_chk u_chk (.*);
`default_nettype wire

//--- bps_host.sv
// host model: register port master
// assumes strobes sampled at rising clk_in edges
`timescale 1ns/1ps
`default_nettype none
module bps_host import bps_pkg::*; (
	input  wire logic                  clk_in,
	input  wire logic [BPS_DATA_W-1:0] rdata_in,
	output var  bps_bus_type           bus_out
);
	initial begin
		bus_out = '0;
	end
	// released lines show inverted values
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		bus_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_in);
		bus_out <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		bus_out <= '{addr: ~a, wdata: '1, wr: 1'b0, rd: 1'b0};
		// read data taken at the edge that ends its cycle
		@(posedge clk_in);
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the supervisor with a reference model
// assumes checker and host model compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb import bps_pkg::*;;
	logic                  clk_in = 1'b0;
	logic                  nrst_in = 1'b0;
	bps_cmp_type           cmp = '0;
	logic [5:0]            bo_lvl = '0;
	logic                  b85 = 1'b0;
	logic                  b75 = 1'b0;
	logic                  loss = 1'b0;
	logic [BPS_TS_W-1:0]   tm = '0;
	logic [15:0]           lf = 16'h002D;
	bps_bus_type           bus;
	logic [BPS_DATA_W-1:0] rdata;
	logic                  bk;
	logic                  hen;
	logic                  trun;
	int                    error_cnt = 0;
	int                    total_checks = 0;
	int                    cyc = 0;
	int                    m_tpl, m_b1, m_b2, m_bo, m_v, m_bk;
	longint                m_pd, m_pu;
	always #4 clk_in = ~clk_in;
	bps_top u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .vdd_lt_bat_m_hys_in(cmp.vdd_lt_bat_m_hys),
		.vdd_gt_bat_p_hys_in(cmp.vdd_gt_bat_p_hys), .vdd_lt_trip_in(cmp.vdd_lt_trip),
		.vdd_gt_trip_p_hys_in(cmp.vdd_gt_trip_p_hys), .vdd_below_level_in(bo_lvl), .bat_below85_in(b85),
		.bat_below75_in(b75), .total_loss_in(loss), .time_in(tm), .addr_in(bus.addr), .wdata_in(bus.wdata),
		.wr_in(bus.wr), .rd_in(bus.rd), .rdata_out(rdata), .backup_out(bk), .host_enable_out(hen),
		.temp_comp_run_out(trun));
	bps_host u_host (.clk_in(clk_in), .rdata_in(rdata), .bus_out(bus));
	function automatic logic [15:0] nxt();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction
	function automatic logic [31:0] exp_st();
		return 32'(m_tpl) << BPS_ST_TPL | 32'(m_b2) << BPS_ST_BAT2 | 32'(m_b1) << BPS_ST_BAT1
			| 32'(m_bo) << BPS_ST_BO | 32'(m_v) << BPS_ST_TSDN_V;
	endfunction
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] e);
		total_checks++;
		if (got !== e) begin
			error_cnt++;
			$display("mismatch %0t: read %h model %h", $time, got, e);
		end
	endtask
	task automatic chk_pin(input logic got, input logic e);
		total_checks++;
		if (got !== e) begin
			error_cnt++;
			$display("mismatch %0t: pin %b model %b", $time, got, e);
		end
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] v;
		u_host.rd_reg(a, v);
		chk_reg(v, e);
	endtask
	task automatic chk_stamps();
		rd_chk(BPS_OFF_TSDN_LO, m_pd[31:0]);
		rd_chk(BPS_OFF_TSDN_HI, 32'(m_pd[47:32]));
		rd_chk(BPS_OFF_TSUP_LO, m_pu[31:0]);
		rd_chk(BPS_OFF_TSUP_HI, 32'(m_pu[47:32]));
	endtask
	// new random time, then comparator change, outputs settle in 3 edges
	task automatic go(input bps_cmp_type c, input logic m, input logic t);
		@(posedge clk_in);
		tm <= {nxt(), nxt(), nxt()};
		@(posedge clk_in);
		cmp <= c;
		repeat (6) @(negedge clk_in);
		if (m && !m_bk && !m_v) m_pd = longint'(tm);
		if (!m && m_bk) m_pu = longint'(tm);
		if (m) m_v = 1;
		m_bk = m;
		chk_pin(bk, m);
		chk_pin(hen, !m);
		chk_pin(trun, t);
	endtask
	task automatic wrap_up();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			wrap_up();
		end
	end
	initial begin
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'b1;
		rd_chk(BPS_OFF_STATUS, 32'h0);
		chk_pin(hen, 1'b1);
		chk_pin(trun, 1'b1);
		rd_chk(4'h3, 32'h0);
		@(posedge clk_in);
		loss <= 1'b1;
		repeat (4) @(posedge clk_in);
		loss <= 1'b0;
		m_tpl = 1;
		rd_chk(BPS_OFF_STATUS, exp_st());
		u_host.wr_reg(BPS_OFF_STATUS, 32'h0);
		m_tpl = 0;
		for (int k = 0; k < 7; k++) begin
			u_host.wr_reg(BPS_OFF_CTRL, 32'(k) << BPS_CT_BOSEL);
			bo_lvl <= (k < 6) ? ~(6'h01 << k) : 6'h3F;
			repeat (4) @(posedge clk_in);
			rd_chk(BPS_OFF_STATUS, exp_st());
			@(posedge clk_in);
			bo_lvl <= 6'h01 << k;
			repeat (4) @(posedge clk_in);
			m_bo = (k < 6);
			rd_chk(BPS_OFF_STATUS, exp_st());
			chk_pin(hen, 1'b1);
			@(posedge clk_in);
			bo_lvl <= '0;
			repeat (3) @(posedge clk_in);
			u_host.wr_reg(BPS_OFF_STATUS, 32'h0);
			m_bo = 0;
		end
		for (int k = 1; k <= 2; k++) begin
			b85 <= 1'b1;
			b75 <= (k == 2);
			repeat (4) @(posedge clk_in);
			u_host.wr_reg(BPS_OFF_CTRL, 32'h1);
			repeat (140) @(posedge clk_in);
			m_b1 = 1;
			m_b2 = (k == 2);
			rd_chk(BPS_OFF_STATUS, exp_st());
		end
		go(4'h8, 1'b0, 1'b1);
		go(4'hA, 1'b1, 1'b0);
		u_host.wr_reg(BPS_OFF_CTRL, 32'h2);
		rd_chk(BPS_OFF_STATUS, 32'h0);
		chk_pin(trun, 1'b0);
		go(4'h1, 1'b0, 1'b1);
		chk_stamps();
		// start a measurement with new levels, then cut it by backup
		b85 <= 1'b0;
		b75 <= 1'b0;
		u_host.wr_reg(BPS_OFF_CTRL, 32'h3);
		go(4'hA, 1'b1, 1'b1);
		go(4'h4, 1'b0, 1'b1);
		chk_stamps();
		repeat (140) @(posedge clk_in);
		rd_chk(BPS_OFF_STATUS, exp_st());
		u_host.wr_reg(BPS_OFF_CTRL, 32'h1 << BPS_CT_TIMESTAMP_CLEAR);
		m_pd = 0;
		m_pu = 0;
		m_v = 0;
		chk_stamps();
		rd_chk(BPS_OFF_STATUS, exp_st());
		// second reset in mid-run: flags and controls back to zero
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		rd_chk(BPS_OFF_STATUS, 32'h0);
		rd_chk(BPS_OFF_CTRL, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
